// ### logic/ssw_supervisor.sv
// supply supervisor with reset sequencing and watchdog timer
`timescale 1ns/1ns
`include "ssw_params.svh"
module ssw_supervisor #(
    parameter int STARTUP_CYC = `SSW_STARTUP_CYC,
    parameter int EXPIRY_CYC = `SSW_EXPIRY_CYC,
    parameter int FAULT_CYC = `SSW_FAULT_CYC,
    parameter int HOLD_CYC = `SSW_HOLD_CYC,
    parameter int SETTLE_CYC = `SSW_SETTLE_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_supply_low,
    input wire logic i_pushbutton_reset_n,
    input wire logic i_pushbutton_driven,
    input wire logic i_watchdog_gate,
    input wire logic i_watchdog_strobe_in,
    output logic o_system_reset_n,
    output logic o_system_reset_oe,
    output logic o_watchdog_fault_out_n,
    output logic o_watchdog_fault_oe
);
    localparam int CW = `SSW_CNT_W;
    localparam int PBW = $clog2(`SSW_PB_DELAY_CYC + 1);

    // =========================================================
    // parameter checks
    initial
    begin
        if (STARTUP_CYC < 1 || EXPIRY_CYC < 1 || FAULT_CYC < 1 || HOLD_CYC < 1
            || SETTLE_CYC < 1)
            $error("ssw_supervisor: every length must be at least one cycle");
        if (STARTUP_CYC >= (1 << CW) || EXPIRY_CYC >= (1 << CW)
            || HOLD_CYC >= (1 << CW) || FAULT_CYC >= (1 << CW)
            || SETTLE_CYC >= (1 << CW))
            $error("ssw_supervisor: a length does not fit the counter width");
    end

    // =========================================================
    // pushbutton input
    logic pb_low;
    logic [PBW-1:0] pb_cnt_r;
    logic [PBW-1:0] pb_cnt_nxt;
    logic pb_assert_r;
    logic pb_assert_nxt;

    // undriven pin reads as released, like the internal pull-up
    assign pb_low = i_pushbutton_driven && !i_pushbutton_reset_n;

    // assertion delayed by the short delay, held while low
    always_comb
    begin
        pb_cnt_nxt = pb_cnt_r;
        pb_assert_nxt = pb_assert_r;
        if (!pb_low)
        begin
            pb_cnt_nxt = '0;
            pb_assert_nxt = 1'b0;
        end
        else if (pb_cnt_r < PBW'(`SSW_PB_DELAY_CYC))
            pb_cnt_nxt = pb_cnt_r + PBW'(1);
        else
            pb_assert_nxt = 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pb_cnt_r <= '0;
            pb_assert_r <= 1'b0;
        end
        else if (i_ce)
        begin
            pb_cnt_r <= pb_cnt_nxt;
            pb_assert_r <= pb_assert_nxt;
        end
    end

    // =========================================================
    // reset sequencer
    ssw_pkg::ssw_rst_e rst_state_r;
    ssw_pkg::ssw_rst_e rst_state_nxt;
    logic [CW-1:0] hold_cnt_r;
    logic [CW-1:0] hold_cnt_nxt;
    logic rst_cause;
    logic rst_release;

    assign rst_cause = i_supply_low || pb_assert_r;

    // a fresh cause always restarts the full hold, so brief glitches still get it
    always_comb
    begin
        rst_state_nxt = rst_state_r;
        hold_cnt_nxt = hold_cnt_r;
        unique case (rst_state_r)
            ssw_pkg::RST_ASSERT:
            begin
                hold_cnt_nxt = '0;
                if (!rst_cause)
                    rst_state_nxt = ssw_pkg::RST_HOLD;
            end
            ssw_pkg::RST_HOLD:
            begin
                if (rst_cause)
                    rst_state_nxt = ssw_pkg::RST_ASSERT;
                else if (hold_cnt_r == CW'(HOLD_CYC - 1))
                    rst_state_nxt = ssw_pkg::RST_RUN;
                else
                    hold_cnt_nxt = hold_cnt_r + CW'(1);
            end
            ssw_pkg::RST_RUN:
            begin
                if (rst_cause)
                    rst_state_nxt = ssw_pkg::RST_ASSERT;
            end
            default:
                rst_state_nxt = ssw_pkg::RST_ASSERT;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rst_state_r <= ssw_pkg::RST_ASSERT;
            hold_cnt_r <= '0;
        end
        else if (i_ce)
        begin
            rst_state_r <= rst_state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
        end
    end

    // one-cycle mark of the reset release
    assign rst_release = (rst_state_r == ssw_pkg::RST_HOLD)
        && (rst_state_nxt == ssw_pkg::RST_RUN);

    // =========================================================
    // gate settle window
    logic gate_prev_r;
    logic [CW-1:0] settle_cnt_r;
    logic [CW-1:0] settle_cnt_nxt;
    logic settling;

    // counts from the gate's rising edge; strobes ignored until done
    always_comb
    begin
        settle_cnt_nxt = settle_cnt_r;
        if (!i_watchdog_gate)
            settle_cnt_nxt = '0;
        else if (!gate_prev_r)
            settle_cnt_nxt = CW'(SETTLE_CYC);
        else if (settle_cnt_r != '0)
            settle_cnt_nxt = settle_cnt_r - CW'(1);
    end

    assign settling = (settle_cnt_r != '0) || (i_watchdog_gate && !gate_prev_r);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            gate_prev_r <= 1'b0;
            settle_cnt_r <= '0;
        end
        else if (i_ce)
        begin
            gate_prev_r <= i_watchdog_gate;
            settle_cnt_r <= settle_cnt_nxt;
        end
    end

    // =========================================================
    // watchdog
    ssw_pkg::ssw_wd_e wd_state_r;
    ssw_pkg::ssw_wd_e wd_state_nxt;
    logic [CW-1:0] wd_cnt_r;
    logic [CW-1:0] wd_cnt_nxt;
    logic strobe_ignore;
    logic valid_fall;

    // strobes ignored in fault, reset, startup, settle or gate low
    assign strobe_ignore = (wd_state_r != ssw_pkg::WD_MON) || settling
        || !i_watchdog_gate || (rst_state_r != ssw_pkg::RST_RUN);

    ssw_strobe_qual #(
        .MIN_CYC(`SSW_STROBE_MIN_CYC)
    ) u_qual (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_clear(strobe_ignore),
        .i_strobe(i_watchdog_strobe_in),
        .o_valid_fall(valid_fall)
    );

    // one counter serves startup, expiry and fault width in turn
    always_comb
    begin
        wd_state_nxt = wd_state_r;
        wd_cnt_nxt = wd_cnt_r;
        unique case (wd_state_r)
            ssw_pkg::WD_IDLE:
            begin
                wd_cnt_nxt = '0;
                if (rst_release)
                    wd_state_nxt = ssw_pkg::WD_START;
            end
            ssw_pkg::WD_START:
            begin
                if (wd_cnt_r == CW'(STARTUP_CYC - 1))
                begin
                    // a gated-off end waits at the final count instead of restarting
                    if (i_watchdog_gate)
                    begin
                        wd_cnt_nxt = '0;
                        wd_state_nxt = ssw_pkg::WD_MON;
                    end
                end
                else
                    wd_cnt_nxt = wd_cnt_r + CW'(1);
            end
            ssw_pkg::WD_MON:
            begin
                if (!i_watchdog_gate || settling)
                    wd_cnt_nxt = '0;
                else if (valid_fall)
                    wd_cnt_nxt = '0;
                else if (wd_cnt_r == CW'(EXPIRY_CYC - 1))
                begin
                    wd_cnt_nxt = '0;
                    wd_state_nxt = ssw_pkg::WD_FAULT;
                end
                else
                    wd_cnt_nxt = wd_cnt_r + CW'(1);
            end
            ssw_pkg::WD_FAULT:
            begin
                if (wd_cnt_r == CW'(FAULT_CYC - 1))
                begin
                    wd_cnt_nxt = '0;
                    wd_state_nxt = ssw_pkg::WD_MON;
                end
                else
                    wd_cnt_nxt = wd_cnt_r + CW'(1);
            end
            default:
                wd_state_nxt = ssw_pkg::WD_IDLE;
        endcase
        // any reset cause aborts the watchdog
        if (rst_state_r != ssw_pkg::RST_RUN && !rst_release)
        begin
            wd_state_nxt = ssw_pkg::WD_IDLE;
            wd_cnt_nxt = '0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wd_state_r <= ssw_pkg::WD_IDLE;
            wd_cnt_r <= '0;
        end
        else if (i_ce)
        begin
            wd_state_r <= wd_state_nxt;
            wd_cnt_r <= wd_cnt_nxt;
        end
    end

    // =========================================================
    // open-drain outputs: level fixed low, enable driven from state
    assign o_system_reset_n = 1'b0;
    assign o_system_reset_oe = (rst_state_r != ssw_pkg::RST_RUN);
    assign o_watchdog_fault_out_n = 1'b0;
    assign o_watchdog_fault_oe = (wd_state_r == ssw_pkg::WD_FAULT);

endmodule : ssw_supervisor

// ### logic/ssw_params.svh
// timing constants and counter width for the supply supervisor watchdog
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH

// clock rate in kHz (10 MHz)
`define SSW_CLK_KHZ 10000
// minimum valid strobe pulse width, ns
`define SSW_STROBE_MIN_NS 1000
`define SSW_STROBE_MIN_CYC ((`SSW_STROBE_MIN_NS * `SSW_CLK_KHZ + 999999) / 1000000)
// gate settle window, us (longest: rounds down)
`define SSW_SETTLE_US 300
`define SSW_SETTLE_CYC ((`SSW_SETTLE_US * `SSW_CLK_KHZ) / 1000)
// pushbutton assert delay, ns (typical, rounded up)
`define SSW_PB_DELAY_NS 250
`define SSW_PB_DELAY_CYC ((`SSW_PB_DELAY_NS * `SSW_CLK_KHZ + 999999) / 1000000)
// default lengths of the long timers, in cycles
`define SSW_STARTUP_CYC 20000
`define SSW_EXPIRY_CYC 16000
`define SSW_FAULT_CYC 1000
`define SSW_HOLD_CYC 2000
// counter width of the shared timers
`define SSW_CNT_W 24

`endif

// ### logic/ssw_pkg.sv
// types for the supply supervisor watchdog
package ssw_pkg;

    // reset sequencer states
    typedef enum logic [2:0]
    {
        RST_ASSERT = 3'h1,
        RST_HOLD = 3'h2,
        RST_RUN = 3'h4
    } ssw_rst_e;

    // watchdog states
    typedef enum logic [3:0]
    {
        WD_IDLE = 4'h1,
        WD_START = 4'h2,
        WD_MON = 4'h4,
        WD_FAULT = 4'h8
    } ssw_wd_e;

endpackage : ssw_pkg

// ### logic/ssw_strobe_qual.sv
// strobe pulse-width qualifier: valid falling edge after a long enough high
`timescale 1ns/1ns
module ssw_strobe_qual #(
    parameter int MIN_CYC = 10
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_clear,
    input wire logic i_strobe,
    output logic o_valid_fall
);
    initial
    begin
        if (MIN_CYC < 1)
            $error("ssw_strobe_qual: MIN_CYC must be at least 1");
    end

    localparam int W = $clog2(MIN_CYC + 1);

    logic prev_r;
    logic prev_nxt;
    logic [W-1:0] width_r;
    logic [W-1:0] width_nxt;
    logic long_r;
    logic long_nxt;

    // width of the current high pulse, saturating at the minimum
    always_comb
    begin
        prev_nxt = i_strobe;
        width_nxt = width_r;
        long_nxt = long_r;
        if (i_clear || !i_strobe)
        begin
            width_nxt = '0;
            long_nxt = 1'b0;
        end
        else if (!long_r)
        begin
            width_nxt = width_r + W'(1);
            long_nxt = (width_r + W'(1)) >= W'(MIN_CYC);
        end
    end

    // narrow pulses never count as a strobe
    assign o_valid_fall = prev_r && !i_strobe && long_r && !i_clear;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            prev_r <= 1'b0;
            width_r <= '0;
            long_r <= 1'b0;
        end
        else if (i_ce)
        begin
            prev_r <= prev_nxt;
            width_r <= width_nxt;
            long_r <= long_nxt;
        end
    end

endmodule : ssw_strobe_qual

// ### testbench/ssw_supervisor_asserts.sv
// checker for reset and watchdog timing at the supervisor ports
`timescale 1ns/1ns
module ssw_supervisor_chk #(
    parameter int STARTUP_CYC = 20,
    parameter int EXPIRY_CYC = 30,
    parameter int FAULT_CYC = 5,
    parameter int HOLD_CYC = 8,
    parameter int SETTLE_CYC = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_supply_low,
    input wire logic i_pushbutton_reset_n,
    input wire logic i_pushbutton_driven,
    input wire logic i_watchdog_gate,
    input wire logic o_system_reset_oe,
    input wire logic o_watchdog_fault_oe
);
    logic [15:0] rel_cnt_r;
    logic [15:0] rel_cnt_nxt;
    default clocking @(posedge i_clk); endclocking
    // a frozen design stretches every timing, so attempts are dropped then
    default disable iff (i_rst || !i_ce);
    // ==========
    // cycles since reset release, saturating so long runs never wrap
    always_comb
    begin
        rel_cnt_nxt = (rel_cnt_r == 16'hffff) ? rel_cnt_r : rel_cnt_r + 16'h0001;
        if (o_system_reset_oe)
            rel_cnt_nxt = 16'h0000;
    end
    always_ff @(posedge i_clk)
        rel_cnt_r <= i_rst ? 16'h0000 : rel_cnt_nxt;
    // ==========
    // reset and fault outputs, the repeat counts follow the small bench values
    AST_SUPPLY_ASSERTS: assert property (i_supply_low |=> o_system_reset_oe)
        else $error("reset not asserted on low supply");
    AST_SUPPLY_HOLD: assert property ($fell(i_supply_low) |-> o_system_reset_oe [*8])
        else $error("reset released before hold time");
    AST_SUPPLY_RELEASE: assert property ($fell(i_supply_low) && i_pushbutton_reset_n |->
        ##[1:12] (!o_system_reset_oe || i_supply_low || !i_pushbutton_reset_n))
        else $error("reset never released after supply recovery");
    AST_PB_ASSERTS: assert property ((!i_pushbutton_reset_n && i_pushbutton_driven) [*7]
        |-> o_system_reset_oe)
        else $error("pushbutton did not assert reset");
    AST_PB_RELEASE: assert property ($rose(i_pushbutton_reset_n) && o_system_reset_oe
        |-> o_system_reset_oe [*8])
        else $error("reset released early after pushbutton");
    AST_FLOAT_NO_RESET: assert property ((!i_pushbutton_driven && !i_supply_low
        && !o_system_reset_oe) [*6] |=> !o_system_reset_oe)
        else $error("floating pushbutton caused reset");
    AST_FAULT_WIDTH: assert property ($rose(o_watchdog_fault_oe)
        |-> o_watchdog_fault_oe [*5] ##1 !o_watchdog_fault_oe)
        else $error("fault pulse width wrong");
    AST_FAULT_NOT_EARLY: assert property ($rose(o_watchdog_fault_oe) |->
        !o_system_reset_oe && rel_cnt_r >= 16'(STARTUP_CYC + EXPIRY_CYC - 2))
        else $error("fault raised too soon after reset");
    AST_FAULT_NEEDS_GATE: assert property ($rose(o_watchdog_fault_oe)
        |-> $past(i_watchdog_gate))
        else $error("fault raised with watchdog gated off");
endmodule : ssw_supervisor_chk

bind ssw_supervisor ssw_supervisor_chk #(.STARTUP_CYC(STARTUP_CYC), .EXPIRY_CYC(EXPIRY_CYC),
    .FAULT_CYC(FAULT_CYC), .HOLD_CYC(HOLD_CYC), .SETTLE_CYC(SETTLE_CYC)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_supply_low(i_supply_low),
    .i_pushbutton_reset_n(i_pushbutton_reset_n), .i_pushbutton_driven(i_pushbutton_driven),
    .i_watchdog_gate(i_watchdog_gate), .o_system_reset_oe(o_system_reset_oe),
    .o_watchdog_fault_oe(o_watchdog_fault_oe));

// ### testbench/ssw_mcu_model.sv
// behavioural processor that strobes the watchdog input
`timescale 1ns/1ns
module ssw_mcu_model (
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [7:0] i_high_cyc,
    output logic o_strobe
);
    logic [7:0] cnt = 8'h00;
    initial o_strobe = 1'b0;
    // ==========
    // high at loop top, low at loop end; a hang freezes the level
    always @(posedge i_clk)
    begin
        if (i_run)
        begin
            cnt <= #1 (cnt >= i_high_cyc + 8'h04) ? 8'h00 : cnt + 8'h01;
            o_strobe <= #1 (cnt < i_high_cyc);
        end
    end
endmodule : ssw_mcu_model

// ### testbench/tb.sv
// self-checking bench for the supply supervisor watchdog
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin miscompares++; \
    $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module tb;
    logic clk = 1'b0, rst = 1'b1, supply_low = 1'b0, pb_n = 1'b1, pb_driven = 1'b1;
    logic gate = 1'b1, strobe, run = 1'b1, reset_oe, fault_oe, fault_q = 1'b0, ce = 1'b1;
    logic [7:0] high_cyc = 8'h0c;
    int miscompares = 0, samples_checked = 0, cycles = 0, rises = 0, n, w;
    localparam int SETTLE = 4;
    localparam int EXPIRY = 30;
    ssw_supervisor #(.STARTUP_CYC(20), .EXPIRY_CYC(EXPIRY), .FAULT_CYC(5), .HOLD_CYC(8),
        .SETTLE_CYC(SETTLE)) dut (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_supply_low(supply_low),
        .i_pushbutton_reset_n(pb_n), .i_pushbutton_driven(pb_driven),
        .i_watchdog_gate(gate), .i_watchdog_strobe_in(strobe), .o_system_reset_n(),
        .o_system_reset_oe(reset_oe), .o_watchdog_fault_out_n(), .o_watchdog_fault_oe(fault_oe));
    ssw_mcu_model mcu (.i_clk(clk), .i_run(run), .i_high_cyc(high_cyc), .o_strobe(strobe));
    // ==========
    // clock, fault pulse counter and hang guard
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        if (fault_oe === 1'b1 && !fault_q)
            rises++;
        fault_q <= fault_oe;
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // inputs move one ns after the edge to stay clear of sampling
    task automatic cyc(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic t_fault();
        for (n = 0; fault_oe !== 1'b1 && n < 80; n++) cyc(1);
        `CHK("fault_seen", 1'b1, fault_oe)
        for (w = 0; fault_oe === 1'b1 && w < 20; w++) cyc(1);
        `CHK("fault_width", 5, w)
    endtask : t_fault
    task automatic t_strobe_ok();
        n = rises;
        cyc(150);
        `CHK("rises_ok", n, rises)
    endtask : t_strobe_ok
    task automatic t_hung_and_narrow();
        run = 1'b0;
        t_fault();
        run = 1'b1;
        high_cyc = 8'h05; // too short to count as a strobe
        t_fault();
        high_cyc = 8'h0c;
        cyc(20);
    endtask : t_hung_and_narrow
    task automatic t_gate_off();
        gate = 1'b0;
        run = 1'b0;
        n = rises;
        cyc(100);
        `CHK("rises_gated", n, rises)
        // strobe still frozen: expiry only starts once the settle window ends
        gate = 1'b1;
        t_fault();
        `CHK("settle_delay", SETTLE + EXPIRY + 1, n)
        run = 1'b1;
        cyc(10);
    endtask : t_gate_off
    task automatic t_freeze();
        supply_low = 1'b1;
        cyc(2);
        supply_low = 1'b0;
        ce = 1'b0;
        cyc(20);
        `CHK("reset_frozen", 1'b1, reset_oe)
        ce = 1'b1;
        cyc(10);
        `CHK("reset_after_freeze", 1'b0, reset_oe)
    endtask : t_freeze
    task automatic t_float();
        pb_driven = 1'b0;
        pb_n = 1'b0;
        cyc(20);
        `CHK("reset_float", 1'b0, reset_oe)
        pb_driven = 1'b1;
        pb_n = 1'b1;
    endtask : t_float
    task automatic t_supply();
        run = 1'b0;
        n = rises;
        supply_low = 1'b1;
        cyc(2);
        `CHK("reset_low_supply", 1'b1, reset_oe)
        cyc(10);
        `CHK("reset_still_low", 1'b1, reset_oe)
        supply_low = 1'b0;
        cyc(7);
        `CHK("reset_in_hold", 1'b1, reset_oe)
        cyc(4);
        `CHK("reset_done", 1'b0, reset_oe)
        `CHK("rises_in_reset", n, rises)
        run = 1'b1;
    endtask : t_supply
    task automatic t_pushbutton();
        pb_n = 1'b0;
        cyc(1);
        `CHK("pb_delay", 1'b0, reset_oe)
        cyc(6);
        `CHK("pb_assert", 1'b1, reset_oe)
        cyc(5);
        pb_n = 1'b1;
        cyc(7);
        `CHK("pb_hold", 1'b1, reset_oe)
        cyc(12);
        `CHK("pb_done", 1'b0, reset_oe)
    endtask : t_pushbutton
    // ==========
    // main sequence
    initial
    begin
        cyc(16);
        rst = 1'b0;
        `CHK("reset_at_start", 1'b1, reset_oe)
        cyc(12);
        `CHK("reset_released", 1'b0, reset_oe)
        t_strobe_ok();
        t_hung_and_narrow();
        t_gate_off();
        t_float();
        t_supply();
        t_pushbutton();
        t_freeze();
        end_of_test();
    end
endmodule : tb
